/* imc_pkg.sv */
package imc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int SCLK_HZ = 2_500_000;
  localparam logic [3:0] SCLK_HALF_CNT = 4'(CLK_HZ / (2 * SCLK_HZ));
  localparam logic [2:0] STRAP_SETTLE_CNT = 3'h4;
  localparam int GP_W = 32;
  localparam int ADDR_HI_W = 14;
  localparam int ADDR_HI_LSB = 0;
  localparam int STRAP_BIT = 13;
  localparam int GLOBAL_BUFFER_INPUT_W = 6;
  localparam int GLOBAL_BUFFER_INPUT_LSB = 14;
  localparam int MC_DONE_BIT = 20;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [1:0] {
    IMC_ST_STRAP,
    IMC_ST_FETCH,
    IMC_ST_SLAVE,
    IMC_ST_DONE
  } imc_state_t;

  // a pin change counts only once the second and third stages agree
  function automatic logic imc_filt(input logic s2, input logic s3,
                                    input logic old);
    return (s2 == s3) ? s3 : old;
  endfunction : imc_filt
endpackage : imc_pkg

/* imc_ser_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface imc_ser_if;
  logic shift_en;
  logic sclk_rise;
  logic bit_in;
  logic byte_valid;
  logic [7:0] byte_data;
  modport ctrl(output shift_en, output sclk_rise, output bit_in,
               input byte_valid, input byte_data);
  modport rx(input shift_en, input sclk_rise, input bit_in,
             output byte_valid, output byte_data);
endinterface : imc_ser_if
`default_nettype wire

/* imc_serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module imc_serial_rx
  import imc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // link to controller
  imc_ser_if.rx ser
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] data;
    logic valid;
  } imc_rx_st_t;

  imc_rx_st_t st_r;
  imc_rx_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (!ser.shift_en) begin
      st_nxt.cnt = 3'h0;
    end else if (ser.sclk_rise) begin
      // msb first, one bit per serial clock rise
      st_nxt.sh = {st_r.sh[6:0], ser.bit_in};
      st_nxt.cnt = st_r.cnt + 3'h1;
      if (st_r.cnt == 3'h7) begin
        st_nxt.data = {st_r.sh[6:0], ser.bit_in};
        st_nxt.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ser.byte_valid = st_r.valid;
  assign ser.byte_data = st_r.data;

  a_byte_on_rise:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    st_r.valid |-> $past(ser.sclk_rise) && $past(ser.shift_en))
  else $error("byte valid without a serial clock rise");
endmodule : imc_serial_rx
`default_nettype wire

/* imc_init_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module imc_init_ctrl
  import imc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // strap and reset pins
  input wire logic rst_pin_n_in,
  input wire logic host_sel_pin_in,
  // init sequencing from the loader
  input wire logic init_done_in,
  input wire logic memory_interface_unit_rd_in,
  input wire logic memory_interface_unit_addr0_in,
  // memory control pins
  output logic ce_n_pin_out,
  output logic ce_n_pin_oe_out,
  output logic oe_n_pin_out,
  output logic oe_n_pin_oe_out,
  output logic a0_pin_out,
  output logic a0_pin_oe_out,
  input wire logic d0_pin_in,
  output logic slave_pullup_en_out,
  // general-purpose pin bank
  input wire logic [GP_W-1:0] gp_pin_in,
  output logic [GP_W-1:0] gp_pin_out,
  output logic [GP_W-1:0] gp_pin_oe_out,
  output logic gp_pullup_en_out,
  // user side of the pin bank
  input wire logic [GP_W-1:0] user_gp_out_in,
  input wire logic [GP_W-1:0] user_gp_oe_in,
  output logic [GP_W-1:0] user_gp_in_out,
  output logic [GLOBAL_BUFFER_INPUT_W-1:0] global_buffer_input_out,
  // multi-chip
  input wire logic multichip_mode_in,
  input wire logic [ADDR_HI_W-1:0] mc_addr_hi_in,
  input wire logic multichip_done_handshake_out_in,
  input wire logic multichip_done_handshake_oe_in,
  output logic multichip_done_handshake_in_out,
  // status
  output logic device_reset_req_out,
  output logic init_complete_out,
  output logic mode_serial_out,
  output logic mode_self_init_out,
  output logic [7:0] prom_byte_out,
  output logic prom_byte_valid_out,
  output logic prom_serial_data_in_out
);
  typedef struct packed {
    imc_state_t state;
    logic [2:0] rst_s;
    logic [2:0] slv_s;
    logic [2:0] pmd_s;
    logic [2:0] sdi_s;
    logic rst_f;
    logic slv_f;
    logic pmd_f;
    logic sdi_f;
    logic [2:0] settle;
    logic self_init;
    logic serial;
    logic [3:0] div;
    logic sclk;
  } imc_top_st_t;

  imc_top_st_t st_r;
  imc_top_st_t st_nxt;
  imc_ser_if ser();
  logic rel;
  logic fetching;
  logic rise;

  // release in the very cycle the loader reports completion
  assign rel = (st_r.state == IMC_ST_DONE) ||
               (init_done_in && (st_r.state == IMC_ST_FETCH ||
                                 st_r.state == IMC_ST_SLAVE));
  assign fetching = (st_r.state == IMC_ST_FETCH) && !rel;
  assign rise = fetching && st_r.serial && !st_r.sclk &&
                (st_r.div == SCLK_HALF_CNT - 4'h1);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_s = {st_r.rst_s[1:0], rst_pin_n_in};
    st_nxt.slv_s = {st_r.slv_s[1:0], host_sel_pin_in};
    st_nxt.pmd_s = {st_r.pmd_s[1:0], gp_pin_in[STRAP_BIT]};
    st_nxt.sdi_s = {st_r.sdi_s[1:0], d0_pin_in};
    st_nxt.rst_f = imc_filt(st_r.rst_s[1], st_r.rst_s[2], st_r.rst_f);
    st_nxt.slv_f = imc_filt(st_r.slv_s[1], st_r.slv_s[2], st_r.slv_f);
    st_nxt.pmd_f = imc_filt(st_r.pmd_s[1], st_r.pmd_s[2], st_r.pmd_f);
    st_nxt.sdi_f = imc_filt(st_r.sdi_s[1], st_r.sdi_s[2], st_r.sdi_f);
    if (fetching && st_r.serial) begin
      if (st_r.div == SCLK_HALF_CNT - 4'h1) begin
        st_nxt.div = 4'h0;
        st_nxt.sclk = !st_r.sclk;
      end else begin
        st_nxt.div = st_r.div + 4'h1;
      end
    end else begin
      st_nxt.div = 4'h0;
      st_nxt.sclk = 1'b0;
    end
    case (st_r.state)
      IMC_ST_STRAP: begin
        // wait for the synchronisers to fill before trusting straps
        if (st_r.settle == STRAP_SETTLE_CNT) begin
          st_nxt.serial = !st_r.pmd_f;
          st_nxt.self_init = st_r.slv_f;
          st_nxt.state = st_r.slv_f ? IMC_ST_FETCH : IMC_ST_SLAVE;
        end else begin
          st_nxt.settle = st_r.settle + 3'h1;
        end
      end
      IMC_ST_FETCH: begin
        if (init_done_in) begin
          st_nxt.state = IMC_ST_DONE;
        end
      end
      IMC_ST_SLAVE: begin
        if (init_done_in) begin
          st_nxt.state = IMC_ST_DONE;
        end
      end
      default: begin
        st_nxt.state = IMC_ST_DONE;
      end
    endcase
    // a reset pin request restarts initialization and re-reads straps
    if (!st_r.rst_f) begin
      st_nxt.state = IMC_ST_STRAP;
      st_nxt.settle = 3'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_r <= '{state: IMC_ST_STRAP, rst_s: SYNC_RST, slv_s: SYNC_RST,
                pmd_s: SYNC_RST, sdi_s: SYNC_RST, rst_f: 1'b1,
                slv_f: 1'b1, pmd_f: 1'b1, sdi_f: 1'b1, settle: 3'h0,
                self_init: 1'b1, serial: 1'b0, div: 4'h0, sclk: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ser.shift_en = fetching && st_r.serial;
  assign ser.sclk_rise = rise;
  assign ser.bit_in = st_r.sdi_f;

  imc_serial_rx u_rx (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ser(ser)
  );

  // memory control: driven only while fetching, floating otherwise
  assign ce_n_pin_oe_out = fetching;
  assign ce_n_pin_out = !memory_interface_unit_rd_in;
  assign oe_n_pin_oe_out = fetching;
  assign oe_n_pin_out = !memory_interface_unit_rd_in;
  assign a0_pin_oe_out = fetching;
  assign a0_pin_out = st_r.serial ? st_r.sclk :
                      memory_interface_unit_addr0_in;
  assign slave_pullup_en_out = !rel && (st_r.state == IMC_ST_SLAVE);

  always_comb begin
    gp_pin_out = '0;
    gp_pin_oe_out = '0;
    for (int i = 0; i < GP_W; i++) begin
      if (!rel) begin
        gp_pin_out[i] = 1'b0;
        gp_pin_oe_out[i] = 1'b0;
      end else if (multichip_mode_in && i >= ADDR_HI_LSB &&
                   i < ADDR_HI_LSB + ADDR_HI_W) begin
        gp_pin_out[i] = mc_addr_hi_in[i - ADDR_HI_LSB];
        gp_pin_oe_out[i] = 1'b1;
      end else if (multichip_mode_in && !st_r.self_init &&
                   i == MC_DONE_BIT) begin
        gp_pin_out[i] = multichip_done_handshake_out_in;
        gp_pin_oe_out[i] = multichip_done_handshake_oe_in;
      end else begin
        gp_pin_out[i] = user_gp_out_in[i];
        gp_pin_oe_out[i] = user_gp_oe_in[i];
      end
    end
  end

  assign gp_pullup_en_out = !rel;
  // raw pins: user logic samples them on its own terms
  assign user_gp_in_out = gp_pin_in;
  assign global_buffer_input_out = gp_pin_in[GLOBAL_BUFFER_INPUT_LSB +: GLOBAL_BUFFER_INPUT_W];
  assign multichip_done_handshake_in_out = gp_pin_in[MC_DONE_BIT];
  assign device_reset_req_out = !st_r.rst_f;
  assign init_complete_out = rel;
  assign mode_serial_out = st_r.serial;
  assign mode_self_init_out = st_r.self_init;
  assign prom_byte_out = ser.byte_data;
  assign prom_byte_valid_out = ser.byte_valid;
  assign prom_serial_data_in_out = st_r.sdi_f;

  a_serial_strap:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (st_r.state == IMC_ST_STRAP && st_r.settle == STRAP_SETTLE_CNT &&
     st_r.rst_f) |=> (mode_serial_out == !$past(st_r.pmd_f)))
  else $error("serial mode does not follow strap");

  a_host_select:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (st_r.state == IMC_ST_STRAP && st_r.settle == STRAP_SETTLE_CNT &&
     st_r.rst_f) |=> (st_r.state == ($past(st_r.slv_f) ? IMC_ST_FETCH :
                                     IMC_ST_SLAVE)))
  else $error("wrong init path for host select");

  a_oe_direction:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (st_r.state == IMC_ST_SLAVE |-> !oe_n_pin_oe_out) and
    (st_r.state == IMC_ST_FETCH && !init_done_in |-> oe_n_pin_oe_out))
  else $error("output-enable pin direction wrong");

  a_ce_direction:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    fetching |-> ce_n_pin_oe_out &&
                 ce_n_pin_out == !memory_interface_unit_rd_in)
  else $error("chip-enable pin not driven during fetch");

  a_pullup_hold:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (st_r.state == IMC_ST_STRAP) |-> gp_pullup_en_out &&
                                     gp_pin_oe_out == '0)
  else $error("pin driven before init complete");

  a_addr_extend:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rel && multichip_mode_in) |->
      gp_pin_out[ADDR_HI_LSB +: ADDR_HI_W] == mc_addr_hi_in &&
      (&gp_pin_oe_out[ADDR_HI_LSB +: ADDR_HI_W]))
  else $error("upper address not driven in multi-chip mode");

  a_done_handshake:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rel && multichip_mode_in && !mode_self_init_out) |->
      gp_pin_oe_out[MC_DONE_BIT] == multichip_done_handshake_oe_in)
  else $error("done pin not carrying handshake");

  a_reset_request:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!st_r.rst_s[1] && !st_r.rst_s[2]) |=>
      device_reset_req_out ##1 (st_r.state == IMC_ST_STRAP))
  else $error("reset pin low not taken as request");

  a_release_same:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (init_done_in && st_r.state == IMC_ST_FETCH) |->
      !gp_pullup_en_out &&
      gp_pin_oe_out[GP_W-1:ADDR_HI_W] == user_gp_oe_in[GP_W-1:ADDR_HI_W] &&
      (multichip_mode_in ||
       gp_pin_oe_out[ADDR_HI_W-1:0] == user_gp_oe_in[ADDR_HI_W-1:0]))
  else $error("pins not released with init complete");

  a_sclk_on_a0:
  assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fetching && mode_serial_out) |-> a0_pin_oe_out &&
      a0_pin_out == st_r.sclk)
  else $error("serial clock missing on address bit 0");
endmodule : imc_init_ctrl
`default_nettype wire

/* imc_prom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module imc_prom_model (
  // pins seen by the serial prom
  input wire logic sclk_in,
  input wire logic ce_n_in,
  input wire logic [7:0] byte_in,
  output logic d0_out
);
  logic [2:0] idx_r;
  // next bit launches on the clock rise, so it stands a whole period
  always @(posedge sclk_in or posedge ce_n_in) begin
    if (ce_n_in)
      idx_r <= 3'h0;
    else
      idx_r <= idx_r + 3'h1;
  end
  // deselected: drive the inverse so no stale bit passes for data
  assign d0_out = ce_n_in ? ~byte_in[7] : byte_in[3'h7 - idx_r];
endmodule : imc_prom_model
`default_nettype wire

/* init_mode_pin_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module init_mode_pin_control_tb_top
  import imc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic rst_n = 1'b1, host_sel = 1'b1, done = 1'b0, rd = 1'b1, addr0 = 1'b0;
  logic mc_mode = 1'b0, hs_out = 1'b0, hs_oe = 1'b0;
  logic [GP_W-1:0] gp_in = 32'hffff_ffff, u_out = 32'h0, u_oe = 32'h0;
  logic [ADDR_HI_W-1:0] mc_addr = 14'h0000;
  logic [7:0] prom_byte = 8'h80;
  logic ce_n_o, ce_oe, oe_n_o, oe_oe, a0_o, a0_oe, d0, slv_pu, gp_pu;
  logic hs_in, rst_req, init_cmp, m_ser, m_self, pvalid, psdi;
  logic [GP_W-1:0] gp_out, gp_oe, ugp_in;
  logic [GLOBAL_BUFFER_INPUT_W-1:0] global_buffer_input;
  logic [7:0] pbyte;
  logic [31:0] seed = 32'h78726cff;
  int n_errors = 0;
  int tests_run = 0;
  // host side of ce and slave-mode a0 float high on pull-ups
  wire ce_w = ce_oe ? ce_n_o : 1'b1;
  wire a0_w = a0_oe ? a0_o : 1'b1;

  always #12.5 core_clk_in = ~core_clk_in;

  imc_init_ctrl i_imc_init_ctrl (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .rst_pin_n_in(rst_n), .host_sel_pin_in(host_sel),
    .init_done_in(done), .memory_interface_unit_rd_in(rd),
    .memory_interface_unit_addr0_in(addr0), .ce_n_pin_out(ce_n_o),
    .ce_n_pin_oe_out(ce_oe), .oe_n_pin_out(oe_n_o), .oe_n_pin_oe_out(oe_oe),
    .a0_pin_out(a0_o), .a0_pin_oe_out(a0_oe), .d0_pin_in(d0),
    .slave_pullup_en_out(slv_pu), .gp_pin_in(gp_in), .gp_pin_out(gp_out),
    .gp_pin_oe_out(gp_oe), .gp_pullup_en_out(gp_pu),
    .user_gp_out_in(u_out), .user_gp_oe_in(u_oe), .user_gp_in_out(ugp_in),
    .global_buffer_input_out(global_buffer_input), .multichip_mode_in(mc_mode),
    .mc_addr_hi_in(mc_addr), .multichip_done_handshake_out_in(hs_out),
    .multichip_done_handshake_oe_in(hs_oe),
    .multichip_done_handshake_in_out(hs_in),
    .device_reset_req_out(rst_req), .init_complete_out(init_cmp),
    .mode_serial_out(m_ser), .mode_self_init_out(m_self),
    .prom_byte_out(pbyte), .prom_byte_valid_out(pvalid),
    .prom_serial_data_in_out(psdi));

  imc_prom_model i_imc_prom_model (.sclk_in(a0_w), .ce_n_in(ce_w),
    .byte_in(prom_byte), .d0_out(d0));

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  // bank after release: multichip takes address pins, done pin only as slave
  function automatic logic [31:0] exp_bank(input logic [31:0] u,
    input logic [13:0] a, input logic h, input logic mc, input logic slf);
    logic [31:0] e;
    e = u;
    if (mc)
      e[13:0] = a;
    if (mc && !slf)
      e[20] = h;
    return e;
  endfunction : exp_bank

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge core_clk_in);
      if ((sel == 0 ? pvalid : sel == 1 ? rst_req : gp_pu) === 1'b1)
        break;
    end
    if (i == 400) begin
      n_errors++;
      test_done;
    end
  endtask : wait_hi

  task automatic start(input logic strap, input logic host);
    logic [31:0] r;
    r = nxt();
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    done <= 1'b0;
    gp_in <= {r[31:14], strap, r[12:0]};
    host_sel <= host;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (8) @(negedge core_clk_in);
  endtask : start

  task automatic release_bank(input logic slf);
    @(posedge core_clk_in);
    mc_mode <= 1'b1;
    mc_addr <= 14'(nxt() >> 18);
    hs_out <= 1'(nxt() >> 31);
    hs_oe <= 1'b1;
    u_out <= nxt();
    u_oe <= nxt();
    gp_in <= nxt();
    done <= 1'b1;
    @(negedge core_clk_in);
    check(gp_pu, 1'b0);
    check(init_cmp, 1'b1);
    check(gp_out, exp_bank(u_out, mc_addr, hs_out, 1'b1, slf));
    check(gp_oe, exp_bank(u_oe, 14'h3fff, hs_oe, 1'b1, slf));
    check(hs_in, gp_in[20]);
    check(global_buffer_input, gp_in[19:14]);
    check(ugp_in, gp_in);
  endtask : release_bank

  initial begin
    // serial self init, corner byte first then random ones
    start(1'b0, 1'b1);
    check({m_ser, m_self}, 2'h3);
    check({ce_oe, oe_oe, a0_oe, ce_n_o}, 4'he);
    check(gp_pu, 1'b1);
    check(gp_oe, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wait_hi(0);
      check(pbyte, prom_byte);
      check(psdi, prom_byte[0]);
      @(posedge core_clk_in);
      prom_byte <= 8'(nxt() >> 24);
    end
    release_bank(1'b1);
    check(ce_oe, 1'b0);
    // parallel self init: pins follow the loader strobe and address
    start(1'b1, 1'b1);
    check({m_ser, m_self}, 2'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_in);
      rd <= k[0];
      addr0 <= ~k[0];
      @(negedge core_clk_in);
      check({oe_n_o, ce_n_o, a0_o}, {3{~k[0]}});
    end
    // slave init with multichip handover
    start(1'b1, 1'b0);
    check({m_self, ce_oe, oe_oe, a0_oe, slv_pu}, 5'h01);
    check(gp_pu, 1'b1);
    release_bank(1'b0);
    // reset pin low restarts initialization
    @(posedge core_clk_in);
    rst_n <= 1'b0;
    wait_hi(1);
    check(rst_req, 1'b1);
    wait_hi(2);
    check(init_cmp, 1'b0);
    test_done;
  end
endmodule : init_mode_pin_control_tb_top
`default_nettype wire
